// ### plane_cap_consts.vh
`ifndef PLANE_CAP_CONSTS_VH
`define PLANE_CAP_CONSTS_VH

// Register index offsets inside one domain
`define OFS_LIMIT 3'h0
`define OFS_ENERGY 3'h1
`define OFS_POLICY 3'h2
`define OFS_PERF 3'h3
`define OFS_INFO 3'h4

// Power cap word layout
`define CAP_HI 14
`define CAP_LO 0
`define CAP_EN 15
`define CAP_CLAMP 16
`define CAP_WIN_HI 23
`define CAP_WIN_LO 17
`define CAP_LOCK 63
`define CAP_KEEP_HI 23

// Time window sub-fields, relative to the seven-bit field
`define WIN_Y_HI 4
`define WIN_Y_LO 0
`define WIN_F_HI 6
`define WIN_F_LO 5
`define WIN_ONE_TENTHS 4'ha

// Priority field and its reset values; graphics favoured
`define PRIO_HI 4
`define PRIO_LO 0
`define CORE_PRIO_RST 5'h00
`define GFX_PRIO_RST 5'h10

// Counter field of energy and throttle words
`define CNT_HI 31
`define CNT_LO 0

// Power range word layout
`define RNG_TDP_LO 0
`define RNG_MIN_LO 16
`define RNG_MAX_LO 32
`define RNG_WIN_LO 48

// Counter refresh period
`define REFRESH_NS 1000000
`define CLOCK_NS 10

`endif

// ### wrap_accum.v
`timescale 1ns/100ps
`default_nettype none

// Free-running wrapping accumulator with a published copy
module wrap_accum #(
	parameter W = 32,
	parameter AMT_W = 16
) (
	input wire clock,
	input wire rst_b,
	input wire inc,
	input wire [AMT_W-1:0] amount,
	input wire publish,
	output reg [W-1:0] count_q
);

	reg [W-1:0] running_q; // Internal running total

	// Accumulate, wrapping silently past all ones
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			running_q <= {W{1'b0}};
		end else if (inc) begin
			running_q <= running_q + {{(W-AMT_W){1'b0}}, amount}; // R20
		end
	end

	// Copy the running total to the visible count on publish
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= {W{1'b0}};
		end else if (publish) begin
			count_q <= running_q;
		end
	end

endmodule // wrap_accum

`default_nettype wire

// ### plane_dram_power_cap_regs.v
// Operation
// R01: Limit register holds 15-bit power cap
// R02: Bit above cap enables cap enforcement
// R03: Clamp bit allows going below requested state
// R04: Window field encodes two-power-Y times F
// R05: Plane lock blocks limit and policy writes
// R06: Each plane locks independently of other
// R07: Energy counters read-only, low 32 bits
// R08: Energy counters refresh about every millisecond
// R09: Five-bit priority, 31 is highest
// R10: Default priorities favour the graphics plane
// R11: Core throttle time counter read-only
// R12: Core throttle server only; graphics client only
// R13: Memory domain registers exist on servers only
// R14: Memory cap, enable and window fields
// R15: Memory lock blocks memory cap writes
// R16: Power range reports typical, minimum, maximum
// R17: Power range also reports largest window
// R18: Memory throttle time counter read-only
// R19: Limit at offset 0, energy at 1
// R20: Accumulators wrap modulo two to 32
// R21: Reset clears every lock bit
`timescale 1ns/100ps
`default_nettype none
`include "plane_cap_consts.vh"

module plane_dram_power_cap_regs #(
	parameter SERVER_CFG = 0,
	parameter ADDR_W = 12,
	parameter [ADDR_W-1:0] CORE_BASE = 12'h010,
	parameter [ADDR_W-1:0] GFX_BASE = 12'h020,
	parameter [ADDR_W-1:0] MEM_BASE = 12'h030,
	parameter AMT_W = 16,
	parameter REFRESH_CYCLES = `REFRESH_NS / `CLOCK_NS,
	parameter [14:0] MEM_TDP = 15'h0000,
	parameter [14:0] MEM_MIN_PWR = 15'h0000,
	parameter [14:0] MEM_MAX_PWR = 15'h0000,
	parameter [6:0] MEM_MAX_WIN = 7'h00
) (
	input wire clock,
	input wire rst_b,
	input wire msr_req,
	input wire msr_we,
	input wire [ADDR_W-1:0] msr_addr,
	input wire [63:0] msr_wdata,
	output reg msr_done_q,
	output reg msr_fault_q,
	output reg [63:0] msr_rdata_q,
	input wire core_energy_vld,
	input wire [AMT_W-1:0] core_energy_amt,
	input wire gfx_energy_vld,
	input wire [AMT_W-1:0] gfx_energy_amt,
	input wire mem_energy_vld,
	input wire [AMT_W-1:0] mem_energy_amt,
	input wire time_unit_tick,
	input wire core_throttled,
	input wire mem_throttled,
	output reg [23:0] core_cap_q,
	output reg [23:0] gfx_cap_q,
	output reg [23:0] mem_cap_q,
	output reg [35:0] core_window_tenths_q,
	output reg [35:0] gfx_window_tenths_q,
	output reg [35:0] mem_window_tenths_q,
	output reg [4:0] core_prio_q,
	output reg [4:0] gfx_prio_q
);

	// Which register groups this configuration provides
	localparam HAS_GFX = (SERVER_CFG == 0); // R12
	localparam HAS_CORE_PERF = (SERVER_CFG != 0); // R12
	localparam HAS_MEM = (SERVER_CFG != 0); // R13
	localparam CNT_W = 18;

	reg core_lock_q; // Core plane lock
	reg gfx_lock_q; // Graphics plane lock
	reg mem_lock_q; // Memory domain lock
	reg [CNT_W-1:0] refresh_cnt_q; // Millisecond divider
	reg refresh_tick_q; // One-cycle refresh enable
	reg [63:0] rdata_d; // Read mux result
	reg fault_d; // Access refused
	wire [31:0] core_energy; // Published counters
	wire [31:0] gfx_energy;
	wire [31:0] mem_energy;
	wire [31:0] core_thr_time;
	wire [31:0] mem_thr_time;
	wire wr; // Write request
	wire [AMT_W-1:0] one_unit; // Throttle increment

	// Address match of a domain base plus offset
	function hit;
		input [ADDR_W-1:0] a;
		input [ADDR_W-1:0] base;
		input [2:0] ofs;
		begin
			hit = (a == base + {{(ADDR_W-3){1'b0}}, ofs}); // R19
		end
	endfunction

	// Window in tenths of a time unit: (10 + z) shifted by y
	function [35:0] win_tenths;
		input [6:0] w;
		reg [35:0] f;
		begin
			f = {32'h00000000, `WIN_ONE_TENTHS
				+ {2'b00, w[`WIN_F_HI:`WIN_F_LO]}}; // R04
			win_tenths = f << w[`WIN_Y_HI:`WIN_Y_LO]; // R04
		end
	endfunction

	// Keep writable cap bits; clamp exists only on planes
	function [23:0] cap_bits;
		input [63:0] d;
		input clamp_ok;
		begin
			cap_bits = d[`CAP_KEEP_HI:`CAP_LO]; // R01 R02 R14
			cap_bits[`CAP_CLAMP] = clamp_ok & d[`CAP_CLAMP]; // R03
		end
	endfunction

	// Read the cap word back with its lock bit on top
	function [63:0] cap_word;
		input [23:0] c;
		input lock;
		begin
			cap_word = 64'h0000000000000000;
			cap_word[`CAP_KEEP_HI:`CAP_LO] = c;
			cap_word[`CAP_LOCK] = lock;
		end
	endfunction

	assign wr = msr_req & msr_we;
	assign one_unit = {{(AMT_W-1){1'b0}}, 1'b1};

	// Millisecond refresh enable for energy counters
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			refresh_cnt_q <= {CNT_W{1'b0}};
			refresh_tick_q <= 1'b0;
		end else if (refresh_cnt_q == REFRESH_CYCLES[CNT_W-1:0] - 1'b1) begin
			// Last count: wrap and pulse the enable
			refresh_cnt_q <= {CNT_W{1'b0}};
			refresh_tick_q <= 1'b1; // R08
		end else begin
			// Count toward the next refresh
			refresh_cnt_q <= refresh_cnt_q + 1'b1;
			refresh_tick_q <= 1'b0;
		end
	end

	// Energy counters, published on the refresh enable
	wrap_accum #(.W(32), .AMT_W(AMT_W)) u_core_energy (
		.clock(clock),
		.rst_b(rst_b),
		.inc(core_energy_vld),
		.amount(core_energy_amt),
		.publish(refresh_tick_q),
		.count_q(core_energy)
	);

	wrap_accum #(.W(32), .AMT_W(AMT_W)) u_gfx_energy (
		.clock(clock),
		.rst_b(rst_b),
		.inc(gfx_energy_vld),
		.amount(gfx_energy_amt),
		.publish(refresh_tick_q),
		.count_q(gfx_energy)
	);

	wrap_accum #(.W(32), .AMT_W(AMT_W)) u_mem_energy (
		.clock(clock),
		.rst_b(rst_b),
		.inc(mem_energy_vld),
		.amount(mem_energy_amt),
		.publish(refresh_tick_q),
		.count_q(mem_energy)
	);

	// Throttled-time counters, one unit per tick while held
	wrap_accum #(.W(32), .AMT_W(AMT_W)) u_core_thr (
		.clock(clock),
		.rst_b(rst_b),
		.inc(time_unit_tick & core_throttled), // R11
		.amount(one_unit),
		.publish(1'b1),
		.count_q(core_thr_time)
	);

	wrap_accum #(.W(32), .AMT_W(AMT_W)) u_mem_thr (
		.clock(clock),
		.rst_b(rst_b),
		.inc(time_unit_tick & mem_throttled), // R18
		.amount(one_unit),
		.publish(1'b1),
		.count_q(mem_thr_time)
	);

	// Core plane cap and priority, gated by its own lock
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			core_cap_q <= 24'h000000;
			core_lock_q <= 1'b0; // R21
			core_prio_q <= `CORE_PRIO_RST; // R10
		end else if (wr && !core_lock_q) begin // R05 R06
			// Cap write may set the lock in the same access
			if (hit(msr_addr, CORE_BASE, `OFS_LIMIT)) begin
				core_cap_q <= cap_bits(msr_wdata, 1'b1);
				core_lock_q <= msr_wdata[`CAP_LOCK]; // R05
			end
			// Priority write
			if (hit(msr_addr, CORE_BASE, `OFS_POLICY)) begin
				core_prio_q <= msr_wdata[`PRIO_HI:`PRIO_LO]; // R09
			end
		end
	end

	// Graphics plane cap and priority, client only
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			gfx_cap_q <= 24'h000000;
			gfx_lock_q <= 1'b0; // R21
			gfx_prio_q <= `GFX_PRIO_RST; // R10
		end else if (wr && !gfx_lock_q && HAS_GFX) begin // R05 R06 R12
			// Cap write may set the lock in the same access
			if (hit(msr_addr, GFX_BASE, `OFS_LIMIT)) begin
				gfx_cap_q <= cap_bits(msr_wdata, 1'b1);
				gfx_lock_q <= msr_wdata[`CAP_LOCK]; // R05
			end
			// Priority write
			if (hit(msr_addr, GFX_BASE, `OFS_POLICY)) begin
				gfx_prio_q <= msr_wdata[`PRIO_HI:`PRIO_LO]; // R09
			end
		end
	end

	// Memory domain cap, server only, no clamp bit
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mem_cap_q <= 24'h000000;
			mem_lock_q <= 1'b0; // R21
		end else if (wr && !mem_lock_q && HAS_MEM
			&& hit(msr_addr, MEM_BASE, `OFS_LIMIT)) begin // R13 R15
			// Write may set the lock in the same access
			mem_cap_q <= cap_bits(msr_wdata, 1'b0); // R14
			mem_lock_q <= msr_wdata[`CAP_LOCK]; // R15
		end
	end

	// Decoded windows for the budgeting logic
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			core_window_tenths_q <= 36'h000000000;
			gfx_window_tenths_q <= 36'h000000000;
			mem_window_tenths_q <= 36'h000000000;
		end else begin
			// Each window trails its stored field by one cycle
			core_window_tenths_q <=
				win_tenths(core_cap_q[`CAP_WIN_HI:`CAP_WIN_LO]); // R04
			gfx_window_tenths_q <=
				win_tenths(gfx_cap_q[`CAP_WIN_HI:`CAP_WIN_LO]); // R04
			mem_window_tenths_q <=
				win_tenths(mem_cap_q[`CAP_WIN_HI:`CAP_WIN_LO]); // R04
		end
	end

	// Read mux and refusal of absent or read-only targets
	always @* begin
		rdata_d = 64'h0000000000000000;
		fault_d = 1'b0;
		if (hit(msr_addr, CORE_BASE, `OFS_LIMIT)) begin
			// Core cap word with lock on top
			rdata_d = cap_word(core_cap_q, core_lock_q);
		end else if (hit(msr_addr, CORE_BASE, `OFS_ENERGY)) begin
			// Core energy, writes refused
			rdata_d[`CNT_HI:`CNT_LO] = core_energy; // R07
			fault_d = msr_we; // R07
		end else if (hit(msr_addr, CORE_BASE, `OFS_POLICY)) begin
			// Core priority
			rdata_d[`PRIO_HI:`PRIO_LO] = core_prio_q;
		end else if (hit(msr_addr, CORE_BASE, `OFS_PERF)) begin
			// Core throttle time, server only
			rdata_d[`CNT_HI:`CNT_LO] = core_thr_time; // R11
			fault_d = msr_we | !HAS_CORE_PERF; // R11 R12
		end else if (hit(msr_addr, GFX_BASE, `OFS_LIMIT)) begin
			// Graphics cap word, client only
			rdata_d = cap_word(gfx_cap_q, gfx_lock_q);
			fault_d = !HAS_GFX; // R12
		end else if (hit(msr_addr, GFX_BASE, `OFS_ENERGY)) begin
			// Graphics energy, client only
			rdata_d[`CNT_HI:`CNT_LO] = gfx_energy; // R07
			fault_d = msr_we | !HAS_GFX; // R07 R12
		end else if (hit(msr_addr, GFX_BASE, `OFS_POLICY)) begin
			// Graphics priority, client only
			rdata_d[`PRIO_HI:`PRIO_LO] = gfx_prio_q;
			fault_d = !HAS_GFX; // R12
		end else if (hit(msr_addr, MEM_BASE, `OFS_LIMIT)) begin
			// Memory cap word, server only
			rdata_d = cap_word(mem_cap_q, mem_lock_q);
			fault_d = !HAS_MEM; // R13
		end else if (hit(msr_addr, MEM_BASE, `OFS_ENERGY)) begin
			// Memory energy, server only
			rdata_d[`CNT_HI:`CNT_LO] = mem_energy; // R07
			fault_d = msr_we | !HAS_MEM; // R07 R13
		end else if (hit(msr_addr, MEM_BASE, `OFS_PERF)) begin
			// Memory throttle time, server only
			rdata_d[`CNT_HI:`CNT_LO] = mem_thr_time; // R18
			fault_d = msr_we | !HAS_MEM; // R18 R13
		end else if (hit(msr_addr, MEM_BASE, `OFS_INFO)) begin
			// Power range, fixed by parameters
			rdata_d[`RNG_TDP_LO+14:`RNG_TDP_LO] = MEM_TDP; // R16
			rdata_d[`RNG_MIN_LO+14:`RNG_MIN_LO] = MEM_MIN_PWR; // R16
			rdata_d[`RNG_MAX_LO+14:`RNG_MAX_LO] = MEM_MAX_PWR; // R16
			rdata_d[`RNG_WIN_LO+6:`RNG_WIN_LO] = MEM_MAX_WIN; // R17
			fault_d = msr_we | !HAS_MEM; // R13
		end else begin
			// Unmapped index
			fault_d = 1'b1;
		end
		// Absent registers read as zero
		if (fault_d) begin
			rdata_d = 64'h0000000000000000;
		end
	end

	// Registered answer one cycle after each request
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			msr_done_q <= 1'b0;
			msr_fault_q <= 1'b0;
			msr_rdata_q <= 64'h0000000000000000;
		end else begin
			msr_done_q <= msr_req;
			// Fault and data stand only with the done pulse
			msr_fault_q <= msr_req & fault_d;
			// Data only on a read request
			if (msr_req && !msr_we) begin
				msr_rdata_q <= rdata_d;
			end else begin
				// Idle cycles and writes answer zero
				msr_rdata_q <= 64'h0000000000000000;
			end
		end
	end

endmodule // plane_dram_power_cap_regs

`default_nettype wire

// ### cap_regs_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the capping register bank, client build
module cap_regs_checker #(
	parameter ADDR_W = 12
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic msr_req,
	input wire logic msr_we,
	input wire logic [ADDR_W-1:0] msr_addr,
	input wire logic msr_done_q,
	input wire logic msr_fault_q,
	input wire logic [63:0] msr_rdata_q,
	input wire logic [23:0] core_cap_q,
	input wire logic [35:0] core_window_tenths_q,
	input wire logic [4:0] gfx_prio_q
);
	// One clock domain, async reset
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	// Write aimed at the core energy counter
	wire ro_wr = msr_req && msr_we && msr_addr == 12'h011;
	// Access to the memory group, absent on a client
	wire mem_acc = msr_req && msr_addr[11:4] == 8'h03;
	property p_answer; msr_req |=> msr_done_q; endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_idle; !msr_req |=> !msr_done_q && !msr_fault_q; endproperty
	a_idle: assert property (p_idle) else $error("stray answer");
	property p_rdata; !msr_done_q |-> msr_rdata_q == 64'h0; endproperty
	a_rdata: assert property (p_rdata) else $error("data off");
	property p_ro; ro_wr |=> msr_fault_q && msr_done_q; endproperty
	a_ro: assert property (p_ro) else $error("counter write taken");
	property p_mem; mem_acc |=> msr_fault_q; endproperty
	a_mem: assert property (p_mem) else $error("memory group seen");
	property p_thr; msr_req && msr_addr == 12'h013 |=> msr_fault_q;
	endproperty
	a_thr: assert property (p_thr) else $error("throttle seen");
	property p_cap; msr_req && msr_addr == 12'h010 |=> !msr_fault_q;
	endproperty
	a_cap: assert property (p_cap) else $error("cap refused");
	property p_win;
		$changed(core_cap_q) |=> core_window_tenths_q ==
			((36'd10 + $past(core_cap_q[23:22])) << $past(core_cap_q[21:17]));
	endproperty
	a_win: assert property (p_win) else $error("window wrong");
	property p_prio; $rose(rst_b) |-> gfx_prio_q == 5'h10; endproperty
	a_prio: assert property (p_prio) else $error("prio reset");
	// Main scenarios
	c_write: cover property (msr_req && msr_we);
	c_fault: cover property (msr_fault_q);
	c_cap: cover property ($changed(core_cap_q));
endmodule // cap_regs_checker

bind plane_dram_power_cap_regs cap_regs_checker #(.ADDR_W(ADDR_W)) i_chk (
	.clock(clock), .rst_b(rst_b), .msr_req(msr_req), .msr_we(msr_we),
	.msr_addr(msr_addr), .msr_done_q(msr_done_q), .msr_fault_q(msr_fault_q),
	.msr_rdata_q(msr_rdata_q), .core_cap_q(core_cap_q),
	.core_window_tenths_q(core_window_tenths_q), .gfx_prio_q(gfx_prio_q));
`default_nettype wire

// ### plane_dram_power_cap_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
// Client build, short refresh period
module plane_dram_power_cap_regs_tb;
	// One register access and its answer
	typedef struct packed {
		logic we;
		logic [11:0] a;
		logic [63:0] d;
		logic [63:0] r;
		logic f;
	} row_t;
	logic clock = 0, rst_b = 0, req = 0, we = 0, cev = 0, gev = 0;
	logic [11:0] addr = 12'h000;
	logic [63:0] wd = 64'h0;
	logic [15:0] cam = 16'h0, gam = 16'h0;
	logic tick = 0, thr = 0; // Time unit pulse and throttle level
	wire done, fault;
	wire [63:0] rdata;
	wire [23:0] ccap, gcap, mcap;
	wire [35:0] cwin, gwin, mwin;
	wire [4:0] cpr, gpr;
	int err_total = 0, comparisons = 0;
	// Ordinary accesses, with answers expected
	row_t rows [16] = '{
		'{0, 12'h022, 0, 64'h10, 0}, '{1, 12'h010, 64'hff_00ff_ffff, 0, 0},
		'{0, 12'h010, 0, 64'hff_ffff, 0}, '{1, 12'h012, 64'h3f, 0, 0},
		'{0, 12'h012, 0, 64'h1f, 0}, '{1, 12'h011, 64'h1, 0, 1},
		'{0, 12'h013, 0, 0, 1}, '{0, 12'h030, 0, 0, 1},
		'{1, 12'h020, 64'h8000_0000_0000_1234, 0, 0},
		'{1, 12'h020, 64'h5555, 0, 0},
		'{0, 12'h020, 0, 64'h8000_0000_0000_1234, 0},
		'{1, 12'h022, 64'h3, 0, 0}, '{0, 12'h022, 0, 64'h10, 0},
		'{1, 12'h010, 64'h1_0005, 0, 0}, '{0, 12'h010, 0, 64'h1_0005, 0},
		'{0, 12'h0f0, 0, 0, 1}};

	plane_dram_power_cap_regs #(.REFRESH_CYCLES(8)) i_dut (
		.clock(clock), .rst_b(rst_b), .msr_req(req), .msr_we(we),
		.msr_addr(addr), .msr_wdata(wd), .msr_done_q(done),
		.msr_fault_q(fault), .msr_rdata_q(rdata),
		.core_energy_vld(cev), .core_energy_amt(cam),
		.gfx_energy_vld(gev), .gfx_energy_amt(gam),
		.mem_energy_vld(cev), .mem_energy_amt(cam),
		.time_unit_tick(tick), .core_throttled(thr), .mem_throttled(thr),
		.core_cap_q(ccap), .gfx_cap_q(gcap), .mem_cap_q(mcap),
		.core_window_tenths_q(cwin), .gfx_window_tenths_q(gwin),
		.mem_window_tenths_q(mwin), .core_prio_q(cpr), .gfx_prio_q(gpr));

	// Free-running clock
	initial begin
		forever #5 clock = ~clock;
	end

	// Compare and count
	task chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One access, answer looked at in its one cycle
	task acc(input row_t w);
		@(posedge clock);
		req <= 1'b1;
		we <= w.we;
		addr <= w.a;
		wd <= w.d;
		@(posedge clock);
		req <= 1'b0;
		#1;
		chk(done, 1);
		chk(fault, w.f);
		chk(rdata, w.r);
	endtask

	// Counts, verdict, end of run
	task conclude;
		$display("Errors %0d in %0d comparisons", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Hang guard
	initial begin
		#100000;
		err_total++;
		conclude();
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		#1;
		chk(gpr, 5'h10);
		chk(cpr, 5'h00);
		foreach (rows[i]) acc(rows[i]);
		// Locked plane kept its first cap; memory group absent
		chk(gcap, 24'h00_1234);
		chk(gwin, 36'ha);
		acc('{1, 12'h030, 64'h8000_0000_00ff_ffff, 0, 1});
		chk(mcap, 24'h00_0000);
		chk(mwin, 36'ha);
		// Largest fraction with a big exponent
		acc('{1, 12'h010, 64'hf6_8001, 0, 0});
		chk(ccap, 24'hf6_8001);
		@(posedge clock);
		#1;
		chk(cwin, 36'h0_6800_0000);
		// Five cycles of energy on both planes
		@(posedge clock);
		cev <= 1'b1;
		cam <= 16'h0003;
		gev <= 1'b1;
		gam <= 16'hffff;
		tick <= 1'b1;
		thr <= 1'b1;
		repeat (5) @(posedge clock);
		cev <= 1'b0;
		gev <= 1'b0;
		tick <= 1'b0;
		thr <= 1'b0;
		repeat (20) @(posedge clock);
		acc('{0, 12'h011, 0, 64'hf, 0});
		acc('{0, 12'h021, 0, 64'h4_fffb, 0});
		// Counting but absent groups still refuse and read zero
		acc('{0, 12'h013, 0, 0, 1});
		acc('{0, 12'h031, 0, 0, 1});
		acc('{0, 12'h033, 0, 0, 1});
		// Second reset frees the locked plane
		@(posedge clock);
		rst_b <= 1'b0;
		@(posedge clock);
		rst_b <= 1'b1;
		// One energy unit after release, counted but not yet shown
		cev <= 1'b1;
		cam <= 16'h0001;
		@(posedge clock);
		cev <= 1'b0;
		acc('{0, 12'h011, 0, 0, 0});
		acc('{1, 12'h020, 64'h7, 0, 0});
		acc('{0, 12'h020, 0, 64'h7, 0});
		// First refresh after release shows it
		repeat (2) @(posedge clock);
		acc('{0, 12'h011, 0, 64'h1, 0});
		conclude();
	end
endmodule // plane_dram_power_cap_regs_tb
`default_nettype wire
